// file: hdl/blu_unit.sv
`timescale 1ns/1ps
module blu_unit
	import blu_pkg::*;
#(
	parameter int WORD_W     = BLU_WORD_W,
	parameter bit SIGNED_CMP = BLU_SIGNED_CMP
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  start_i,
	input  wire logic [BLU_OP_W-1:0]   opcode_i,
	input  wire logic [BLU_REG_AW-1:0] first_register_field_i,
	input  wire logic [BLU_REG_AW-1:0] second_register_field_i,
	input  wire logic [WORD_W-1:0]     ea_i,
	input  wire logic [WORD_W-1:0]     next_loc_i,
	input  wire logic [BLU_CC_W-1:0]   cc_i,
	input  wire logic [WORD_W-1:0]     rd_data_i,
	output logic                       busy_o,
	output logic      [BLU_REG_AW-1:0] rd_addr_o,
	output logic                       wr_en_o,
	output logic      [BLU_REG_AW-1:0] wr_addr_o,
	output logic      [WORD_W-1:0]     wr_data_o,
	output logic      [WORD_W-1:0]     location_counter_o,
	output logic                       loc_load_o,
	output logic                       taken_o,
	output logic      [BLU_CC_W-1:0]   cc_o,
	output logic                       done_o,
	output logic                       err_o
);

	// Instruction context captured when a request is taken
	blu_state_t              state_r;
	blu_state_t              state_nxt;
	blu_kind_t               kind_r;
	blu_kind_t               kind_nxt;
	logic                    low_eq_r;
	logic                    low_eq_nxt;
	logic [BLU_REG_AW-1:0]   r1_r;
	logic [BLU_REG_AW-1:0]   r1_nxt;
	logic [WORD_W-1:0]       target_r;
	logic [WORD_W-1:0]       target_nxt;
	logic [WORD_W-1:0]       seq_r;
	logic [WORD_W-1:0]       seq_nxt;
	logic [BLU_CC_W-1:0]     cc_held_r;
	logic [BLU_CC_W-1:0]     cc_held_nxt;

	// Index triple, read one register per cycle through the single read port
	logic [WORD_W-1:0]       index_r;
	logic [WORD_W-1:0]       index_nxt;
	logic [WORD_W-1:0]       incr_r;
	logic [WORD_W-1:0]       incr_nxt;
	logic [WORD_W-1:0]       limit_r;
	logic [WORD_W-1:0]       limit_nxt;

	// Output registers; every port is driven straight from one of these
	logic                    busy_r;
	logic                    busy_nxt;
	logic [BLU_REG_AW-1:0]   rd_addr_r;
	logic [BLU_REG_AW-1:0]   rd_addr_nxt;
	logic                    wr_en_r;
	logic                    wr_en_nxt;
	logic [BLU_REG_AW-1:0]   wr_addr_r;
	logic [BLU_REG_AW-1:0]   wr_addr_nxt;
	logic [WORD_W-1:0]       wr_data_r;
	logic [WORD_W-1:0]       wr_data_nxt;
	logic [WORD_W-1:0]       loc_r;
	logic [WORD_W-1:0]       loc_nxt;
	logic                    loc_load_r;
	logic                    loc_load_nxt;
	logic                    taken_r;
	logic                    taken_nxt;
	logic [BLU_CC_W-1:0]     cc_out_r;
	logic [BLU_CC_W-1:0]     cc_out_nxt;
	logic                    done_r;
	logic                    done_nxt;
	logic                    err_r;
	logic                    err_nxt;

	// Decision results, valid while the captured operands stand
	logic [WORD_W-1:0]       sum;
	logic                    index_taken;
	logic                    false_taken;

	// Adder and comparator live apart so the order of comparison stays a parameter
	blu_cond #(
		.WORD_W     (WORD_W),
		.SIGNED_CMP (SIGNED_CMP)
	) u_cond (
		.index_i       (index_r),
		.incr_i        (incr_r),
		.limit_i       (limit_r),
		.low_eq_i      (low_eq_r),
		.mask_i        (r1_r),
		.cc_i          (cc_held_r),
		.sum_o         (sum),
		.index_taken_o (index_taken),
		.false_taken_o (false_taken)
	);

	// One request at a time: start_i is looked at only while idle, so a
	// request held high through a busy period is ignored rather than queued;
	// the caller must present one pulse per instruction
	always_comb begin
		state_nxt    = state_r;
		kind_nxt     = kind_r;
		low_eq_nxt   = low_eq_r;
		r1_nxt       = r1_r;
		target_nxt   = target_r;
		seq_nxt      = seq_r;
		cc_held_nxt  = cc_held_r;
		index_nxt    = index_r;
		incr_nxt     = incr_r;
		limit_nxt    = limit_r;
		rd_addr_nxt  = rd_addr_r;
		wr_addr_nxt  = wr_addr_r;
		wr_data_nxt  = wr_data_r;
		loc_nxt      = loc_r;
		taken_nxt    = taken_r;
		cc_out_nxt   = cc_out_r;
		wr_en_nxt    = 1'b0;
		loc_load_nxt = 1'b0;
		done_nxt     = 1'b0;
		err_nxt      = 1'b0;

		unique case (state_r)
			BLU_ST_IDLE: begin
				if (start_i) begin
					// Target and sequential address are latched before any
					// register write, so a link or index register that is also
					// an address field still gives its old contents
					r1_nxt      = first_register_field_i;
					target_nxt  = ea_i;
					seq_nxt     = next_loc_i;
					cc_held_nxt = cc_i;
					low_eq_nxt  = (opcode_i == BLU_OP_IDX_LE);
					case (opcode_i)
						BLU_OP_LINK_RX: begin
							kind_nxt  = BLU_K_LINK;
							state_nxt = BLU_ST_EXEC;
						end
						BLU_OP_LINK_RR: begin
							kind_nxt    = BLU_K_LINK;
							rd_addr_nxt = second_register_field_i;
							state_nxt   = BLU_ST_TGT;
						end
						BLU_OP_FALSE_RX: begin
							kind_nxt  = BLU_K_FALSE;
							state_nxt = BLU_ST_EXEC;
						end
						BLU_OP_FALSE_RR: begin
							kind_nxt    = BLU_K_FALSE;
							rd_addr_nxt = second_register_field_i;
							state_nxt   = BLU_ST_TGT;
						end
						BLU_OP_IDX_LE, BLU_OP_IDX_HI: begin
							kind_nxt    = BLU_K_INDEX;
							rd_addr_nxt = first_register_field_i;
							state_nxt   = BLU_ST_IDX0;
						end
						default: begin
							// Other branch forms are executed elsewhere; flag the
							// request and stay idle; no other port changes, though the captured context is reloaded
							err_nxt = 1'b1;
						end
					endcase
				end
			end
			BLU_ST_TGT: begin
				// Register read finishes before the link write in EXEC
				target_nxt = rd_data_i;
				state_nxt  = BLU_ST_EXEC;
			end
			BLU_ST_IDX0: begin
				index_nxt   = rd_data_i;
				// The four-bit sum wraps past register fifteen on its own
				rd_addr_nxt = r1_r + BLU_INCR_OFS;
				state_nxt   = BLU_ST_IDX1;
			end
			BLU_ST_IDX1: begin
				// Limit is read last; the sum is formed from registered operands
				incr_nxt    = rd_data_i;
				rd_addr_nxt = r1_r + BLU_LIMIT_OFS;
				state_nxt   = BLU_ST_IDX2;
			end
			BLU_ST_IDX2: begin
				limit_nxt = rd_data_i;
				state_nxt = BLU_ST_EXEC;
			end
			BLU_ST_EXEC: begin
				// Completion strobes last one cycle; the values behind them hold
				loc_load_nxt = 1'b1;
				done_nxt     = 1'b1;
				// The flags go back exactly as captured; nothing here alters them
				cc_out_nxt   = cc_held_r;
				state_nxt    = BLU_ST_IDLE;
				unique case (kind_r)
					BLU_K_LINK: begin
						// The link write and the jump land in the same cycle
						wr_en_nxt   = 1'b1;
						wr_addr_nxt = r1_r;
						wr_data_nxt = seq_r;
						taken_nxt   = 1'b1;
						// Bit 0 of the target passes untouched; alignment is up to software
						loc_nxt     = target_r;
					end
					BLU_K_INDEX: begin
						// Write-back happens on both outcomes
						wr_en_nxt   = 1'b1;
						wr_addr_nxt = r1_r;
						wr_data_nxt = sum;
						taken_nxt   = index_taken;
						loc_nxt     = index_taken ? target_r : seq_r;
					end
					BLU_K_FALSE: begin
						// No register write; the mask came in on the first field
						taken_nxt = false_taken;
						loc_nxt   = false_taken ? target_r : seq_r;
					end
				endcase
			end
		endcase

		// Busy follows the next state, so it is already low while done_o is
		// high and a new request can be taken in that same cycle
		busy_nxt = (state_nxt != BLU_ST_IDLE);
	end

	// Plain register stage; all decisions are made in the process above
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r    <= BLU_ST_IDLE;
			kind_r     <= BLU_K_LINK;
			low_eq_r   <= 1'b0;
			r1_r       <= BLU_RST_REG;
			target_r   <= '0;
			seq_r      <= '0;
			cc_held_r  <= BLU_RST_CC;
			index_r    <= '0;
			incr_r     <= '0;
			limit_r    <= '0;
			busy_r     <= 1'b0;
			rd_addr_r  <= BLU_RST_REG;
			wr_en_r    <= 1'b0;
			wr_addr_r  <= BLU_RST_REG;
			wr_data_r  <= '0;
			loc_r      <= '0;
			loc_load_r <= 1'b0;
			taken_r    <= 1'b0;
			cc_out_r   <= BLU_RST_CC;
			done_r     <= 1'b0;
			err_r      <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			kind_r     <= kind_nxt;
			low_eq_r   <= low_eq_nxt;
			r1_r       <= r1_nxt;
			target_r   <= target_nxt;
			seq_r      <= seq_nxt;
			cc_held_r  <= cc_held_nxt;
			index_r    <= index_nxt;
			incr_r     <= incr_nxt;
			limit_r    <= limit_nxt;
			busy_r     <= busy_nxt;
			rd_addr_r  <= rd_addr_nxt;
			wr_en_r    <= wr_en_nxt;
			wr_addr_r  <= wr_addr_nxt;
			wr_data_r  <= wr_data_nxt;
			loc_r      <= loc_nxt;
			loc_load_r <= loc_load_nxt;
			taken_r    <= taken_nxt;
			cc_out_r   <= cc_out_nxt;
			done_r     <= done_nxt;
			err_r      <= err_nxt;
		end
	end

	// Ports come straight from flip-flops, so nothing downstream sees a glitch
	assign busy_o             = busy_r;
	assign rd_addr_o          = rd_addr_r;
	assign wr_en_o            = wr_en_r;
	assign wr_addr_o          = wr_addr_r;
	assign wr_data_o          = wr_data_r;
	assign location_counter_o = loc_r;
	assign loc_load_o         = loc_load_r;
	assign taken_o            = taken_r;
	assign cc_o               = cc_out_r;
	assign done_o             = done_r;
	assign err_o              = err_r;

endmodule

// file: hdl/blu_pkg.sv
package blu_pkg;

	// Datapath and field widths
	localparam int BLU_WORD_W  = 32;
	localparam int BLU_REG_AW  = 4;
	localparam int BLU_CC_W    = 4;
	localparam int BLU_OP_W    = 8;

	// Order of the new index against the limit: 0 = logical, 1 = two's complement
	localparam bit BLU_SIGNED_CMP = 1'b0;

	// Operation codes handled by this unit
	localparam logic [BLU_OP_W-1:0] BLU_OP_LINK_RR  = 8'h01;
	localparam logic [BLU_OP_W-1:0] BLU_OP_FALSE_RR = 8'h03;
	localparam logic [BLU_OP_W-1:0] BLU_OP_LINK_RX  = 8'h41;
	localparam logic [BLU_OP_W-1:0] BLU_OP_FALSE_RX = 8'h43;
	localparam logic [BLU_OP_W-1:0] BLU_OP_IDX_HI   = 8'hC0;
	localparam logic [BLU_OP_W-1:0] BLU_OP_IDX_LE   = 8'hC1;

	// Positions of the carry_ovf_gt_lt_flags inside the condition code
	localparam int BLU_CC_C = 3;
	localparam int BLU_CC_V = 2;
	localparam int BLU_CC_G = 1;
	localparam int BLU_CC_L = 0;

	// Register triple offsets from the first_register_field
	localparam logic [BLU_REG_AW-1:0] BLU_INCR_OFS  = 4'h1;
	localparam logic [BLU_REG_AW-1:0] BLU_LIMIT_OFS = 4'h2;

	// Reset values
	localparam logic [BLU_REG_AW-1:0] BLU_RST_REG = 4'h0;
	localparam logic [BLU_CC_W-1:0]   BLU_RST_CC  = 4'h0;

	typedef enum logic [1:0] {
		BLU_K_LINK,
		BLU_K_INDEX,
		BLU_K_FALSE
	} blu_kind_t;

	typedef enum logic [2:0] {
		BLU_ST_IDLE,
		BLU_ST_TGT,
		BLU_ST_IDX0,
		BLU_ST_IDX1,
		BLU_ST_IDX2,
		BLU_ST_EXEC
	} blu_state_t;

endpackage

// file: hdl/blu_cond.sv
`timescale 1ns/1ps
module blu_cond
	import blu_pkg::*;
#(
	parameter int WORD_W     = BLU_WORD_W,
	parameter bit SIGNED_CMP = BLU_SIGNED_CMP
) (
	input  wire logic [WORD_W-1:0]   index_i,
	input  wire logic [WORD_W-1:0]   incr_i,
	input  wire logic [WORD_W-1:0]   limit_i,
	input  wire logic                low_eq_i,
	input  wire logic [BLU_CC_W-1:0] mask_i,
	input  wire logic [BLU_CC_W-1:0] cc_i,
	output logic      [WORD_W-1:0]   sum_o,
	output logic                     index_taken_o,
	output logic                     false_taken_o
);

	logic not_above;

	// Carry out is dropped on purpose; no flag or trap follows an overflow
	assign sum_o = index_i + incr_i;

	// Logical order by default; a parameter selects signed order
	always_comb begin
		if (SIGNED_CMP) begin
			not_above = ($signed(sum_o) <= $signed(limit_i));
		end else begin
			not_above = (sum_o <= limit_i);
		end
	end

	assign index_taken_o = low_eq_i ? not_above : !not_above;

	// Taken only when no selected flag is set
	assign false_taken_o = ((mask_i & cc_i) == BLU_RST_CC);

endmodule

// file: tb/blu_unit_checker.sv
`timescale 1ns/1ps
module blu_unit_checker
	import blu_pkg::*;
#(
	parameter int WORD_W = BLU_WORD_W
) (
	input wire logic		clk_i,
	input wire logic		rst_i,
	input wire logic		start_i,
	input wire logic [7:0]		opcode_i,
	input wire logic [3:0]		first_register_field_i,
	input wire logic [WORD_W-1:0]	ea_i,
	input wire logic [WORD_W-1:0]	next_loc_i,
	input wire logic [3:0]		cc_i,
	input wire logic [WORD_W-1:0]	rd_data_i,
	input wire logic		busy_o,
	input wire logic [3:0]		rd_addr_o,
	input wire logic		wr_en_o,
	input wire logic [3:0]		wr_addr_o,
	input wire logic [WORD_W-1:0]	wr_data_o,
	input wire logic [WORD_W-1:0]	location_counter_o,
	input wire logic		taken_o,
	input wire logic [3:0]		cc_o,
	input wire logic		done_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire [3:0]	r1 = first_register_field_i;
	logic [3:0]	cc_r;
	logic [3:0]	cc_nxt;
	// Status seen at the take edge; the answer must echo it untouched
	always_comb cc_nxt = (start_i && !busy_o) ? cc_i : cc_r;
	always_ff @(posedge clk_i) cc_r <= cc_nxt;
	sequence s_take(logic [7:0] op);
		start_i && !busy_o && opcode_i == op;
	endsequence
	sequence s_take_idx;
		start_i && !busy_o && (opcode_i == BLU_OP_IDX_LE || opcode_i == BLU_OP_IDX_HI);
	endsequence
	sequence s_idx_reads;
		rd_addr_o == $past(r1) ##1 rd_addr_o == $past(r1, 2) + BLU_INCR_OFS
		##1 rd_addr_o == $past(r1, 3) + BLU_LIMIT_OFS;
	endsequence
	property p_link_rx;
		s_take(BLU_OP_LINK_RX) |-> ##2 done_o && wr_en_o && taken_o && wr_addr_o == $past(r1, 2)
			&& wr_data_o == $past(next_loc_i, 2) && location_counter_o == $past(ea_i, 2);
	endproperty
	property p_link_rr;
		s_take(BLU_OP_LINK_RR) |-> ##3 done_o && wr_en_o && wr_addr_o == $past(r1, 3)
			&& location_counter_o == $past(rd_data_i, 2);
	endproperty
	property p_cc;
		done_o |-> cc_o == cc_r;
	endproperty
	property p_idx_rd;
		s_take_idx |-> ##1 s_idx_reads;
	endproperty
	property p_idx_wr;
		s_take_idx |-> ##5 done_o && wr_en_o && wr_addr_o == $past(r1, 5)
			&& wr_data_o == $past(rd_data_i, 4) + $past(rd_data_i, 3);
	endproperty
	property p_idx_le;
		s_take(BLU_OP_IDX_LE) |-> ##5 taken_o == (wr_data_o <= $past(rd_data_i, 2));
	endproperty
	property p_idx_hi;
		s_take(BLU_OP_IDX_HI) |-> ##5 taken_o == (wr_data_o > $past(rd_data_i, 2));
	endproperty
	property p_idx_loc;
		s_take_idx |-> ##5 location_counter_o == (taken_o ? $past(ea_i, 5) : $past(next_loc_i, 5));
	endproperty
	property p_false;
		s_take(BLU_OP_FALSE_RX) |-> ##2 done_o && !wr_en_o
			&& taken_o == (($past(r1, 2) & $past(cc_i, 2)) == 4'h0);
	endproperty
	property p_busy;
		s_take(BLU_OP_LINK_RX) |-> ##1 busy_o ##1 !busy_o;
	endproperty
	a_link_rx: assert property (p_link_rx) else $error("link result wrong");
	a_link_rr: assert property (p_link_rr) else $error("link target wrong");
	a_cc: assert property (p_cc) else $error("status changed");
	a_idx_rd: assert property (p_idx_rd) else $error("triple order wrong");
	a_idx_wr: assert property (p_idx_wr) else $error("index sum wrong");
	a_idx_le: assert property (p_idx_le) else $error("low compare wrong");
	a_idx_hi: assert property (p_idx_hi) else $error("high compare wrong");
	a_idx_loc: assert property (p_idx_loc) else $error("index target wrong");
	a_false: assert property (p_false) else $error("false test wrong");
	a_busy: assert property (p_busy) else $error("busy span wrong");
endmodule

bind blu_unit blu_unit_checker #(.WORD_W(WORD_W)) i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .opcode_i(opcode_i),
	.first_register_field_i(first_register_field_i), .ea_i(ea_i), .next_loc_i(next_loc_i),
	.cc_i(cc_i), .rd_data_i(rd_data_i), .busy_o(busy_o), .rd_addr_o(rd_addr_o),
	.wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
	.location_counter_o(location_counter_o), .taken_o(taken_o), .cc_o(cc_o), .done_o(done_o)
);

// file: tb/blu_unit_tb.sv
`timescale 1ns/1ps
module blu_unit_tb;
	import blu_pkg::*;
	typedef struct packed {
		logic		er, we, tk;
		logic [3:0]	wa, cc;
		logic [31:0]	location_counter, wd;
	} blu_exp_t;
	logic		clk_i = 1'b0;
	logic		rst_i = 1'b1;
	logic		start_i = 1'b0;
	logic [7:0]	opcode_i = 8'h00;
	logic [3:0]	first_register_field_i = 4'h0;
	logic [3:0]	second_register_field_i = 4'h0;
	logic [31:0]	ea_i = 32'h0;
	logic [31:0]	next_loc_i = 32'h0;
	logic [3:0]	cc_i = 4'h0;
	wire [31:0]	rd_data_i;
	logic		busy_o, wr_en_o, loc_load_o, taken_o, done_o, err_o;
	logic [3:0]	rd_addr_o, wr_addr_o, cc_o;
	logic [31:0]	wr_data_o, location_counter_o, r;
	logic [31:0]	rf [16];
	logic [31:0]	lfsr = 32'h0001_5DE9;
	blu_exp_t	q [$];
	blu_exp_t	got;
	int		num_errors = 0;
	int		n_checks = 0;

	always #50 clk_i = ~clk_i;
	assign rd_data_i = rf[rd_addr_o];
	always @(posedge clk_i) if (wr_en_o === 1'b1) rf[wr_addr_o] <= wr_data_o;

	blu_unit i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .opcode_i(opcode_i),
		.first_register_field_i(first_register_field_i), .ea_i(ea_i), .next_loc_i(next_loc_i),
		.second_register_field_i(second_register_field_i), .cc_i(cc_i), .rd_data_i(rd_data_i),
		.busy_o(busy_o), .rd_addr_o(rd_addr_o), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .location_counter_o(location_counter_o), .loc_load_o(loc_load_o),
		.taken_o(taken_o), .cc_o(cc_o), .done_o(done_o), .err_o(err_o)
	);

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Holding start one more cycle must be ignored while busy
	task automatic run(input logic [7:0] op, input logic [3:0] r1, r2, cc, input bit hold);
		blu_exp_t	e;
		logic [31:0]	nl;
		int		k;
		nl = rnd();
		e = '0;
		e.cc = cc;
		e.wa = r1;
		e.tk = 1'b1;
		e.wd = nl;
		e.location_counter = rnd() & 32'hFFFF_FFFE;
		ea_i = e.location_counter;
		if (!op[6]) e.location_counter = rf[r2];
		case (op)
			BLU_OP_LINK_RX, BLU_OP_LINK_RR: e.we = 1'b1;
			BLU_OP_FALSE_RX, BLU_OP_FALSE_RR: e.tk = (r1 & cc) == 4'h0;
			BLU_OP_IDX_LE, BLU_OP_IDX_HI: begin
				e.we = 1'b1;
				e.wd = rf[r1] + rf[r1 + 4'h1];
				e.tk = (e.wd <= rf[r1 + 4'h2]) == op[0];
			end
			default: e.er = 1'b1;
		endcase
		if (!e.tk) e.location_counter = nl;
		q.push_back(e);
		opcode_i = op;
		first_register_field_i = r1;
		second_register_field_i = r2;
		next_loc_i = nl;
		cc_i = cc;
		start_i = 1'b1;
		@(negedge clk_i);
		if (hold) @(negedge clk_i);
		start_i = 1'b0;
		for (k = 0; k < 10 && done_o !== 1'b1 && err_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 10) begin
			chk(1'b0, "no completion");
			give_verdict();
		end
		// Lets an edge pass so start_i is never driven twice in one step
		if (k == 0) @(negedge clk_i);
	endtask
	task automatic idx(input logic [7:0] op, input logic [3:0] r1, input logic [31:0] a, b, c);
		// A write-back still pending from the last instruction lands first
		@(negedge clk_i);
		rf[r1] = a;
		rf[r1 + 4'h1] = b;
		rf[r1 + 4'h2] = c;
		r = rnd();
		run(op, r1, 4'h0, r[3:0], 1'b1);
	endtask

	always @(negedge clk_i) begin
		if (!rst_i && (done_o === 1'b1 || err_o === 1'b1)) begin
			got = q.pop_front();
			chk(err_o === got.er, "error flag");
			if (!got.er) begin
				chk(loc_load_o === 1'b1 && location_counter_o === got.location_counter, "loc");
				chk(taken_o === got.tk, "taken");
				chk(cc_o === got.cc, "status");
				chk(wr_en_o === got.we, "write enable");
				if (got.we) chk(wr_addr_o === got.wa && wr_data_o === got.wd, "wdata");
			end
		end
	end

	initial begin
		for (int i = 0; i < 16; i++) rf[i] = rnd() & 32'hFFFF_FFFE;
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		run(BLU_OP_LINK_RX, 4'h5, 4'h0, 4'h9, 1'b1);
		run(BLU_OP_LINK_RR, 4'h7, 4'h7, 4'h6, 1'b0);
		$display("test link done");
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			run(i[0] ? BLU_OP_FALSE_RR : BLU_OP_FALSE_RX, i[3:0], r[7:4], r[3:0], 1'b0);
		end
		$display("test false branch done");
		idx(BLU_OP_IDX_LE, 4'hE, 32'h0, 32'h1, 32'h9);
		idx(BLU_OP_IDX_LE, 4'hF, 32'h9, 32'h1, 32'h9);
		idx(BLU_OP_IDX_LE, 4'h3, 32'h8, 32'h1, 32'h9);
		idx(BLU_OP_IDX_HI, 4'h1, 32'h9, 32'h1, 32'h9);
		idx(BLU_OP_IDX_HI, 4'h1, 32'h8, 32'h1, 32'h9);
		idx(BLU_OP_IDX_HI, 4'h2, 32'hFFFF_FFFF, 32'h2, 32'h5);
		idx(BLU_OP_IDX_LE, 4'h4, 32'h0, 32'hFFFF_FFFF, 32'h5);
		$display("test index done");
		run(8'h42, 4'h1, 4'h2, 4'h3, 1'b0);
		run(8'h20, 4'h1, 4'h2, 4'h3, 1'b0);
		run(BLU_OP_LINK_RX, 4'hF, 4'h0, 4'hF, 1'b0);
		$display("test refused done");
		repeat (3) @(negedge clk_i);
		chk(q.size() == 0, "results missing");
		give_verdict();
	end
endmodule
